// ---- adcc_map.vh ----
// Register offsets, field positions, reset values and timing counts of the converter controller.
// Assumes a Wishbone slave decoding word indices; byte address is four times the index.
// How it works
// - Channel field picks analog input zero to six
// - Converter-on bit starts continuous conversion
// - Conversion end sets done flag, loads result
// - High result read clears done flag
// - Result bits split high eight, low two
// - Over upper reference gives full scale
// - Under lower reference gives all zeros
// - Slow and speed bits choose clock divider
// - Converter off means amplifier off, no conversions
// - Amplifier select routes input through gain eight
// - Amplifier powers with converter, no extra delay
// - Calibration bit ties amplifier input to zero
// - Low result bits seven to five read zero
// - Runs in wait, stops in halt, stabilises
// - Done flag read-only against software writes
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH
`define ADCC_IDX_CSR      6'h34
`define ADCC_IDX_RES_HI   6'h35
`define ADCC_IDX_RES_LO   6'h36
`define ADCC_CSR_DONE     7
`define ADCC_CSR_SPEED    6
`define ADCC_CSR_ON       5
`define ADCC_LO_CAL       4
`define ADCC_LO_SLOW      3
`define ADCC_LO_AMP       2
`define ADCC_CSR_RESET    8'h00
`define ADCC_LO_RESET     3'h0
`define ADCC_FULL_SCALE   10'h3ff
`define ADCC_ZERO_SCALE   10'h000
`define ADCC_CONV_CLOCKS  11
`define ADCC_STAB_NS      1000
`define ADCC_CLK_NS       50
`define ADCC_STAB_CYCLES  ((`ADCC_STAB_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`endif

// ---- adcc_clkdiv.v ----
// Converter clock tick generator: one-cycle tick at the CPU rate divided by 1, 2 or 4.
// Assumes a synchronous active-high reset and the CPU clock on clk_i.
`timescale 1ns/1ns
module adcc_clkdiv (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       run_i,
	input  wire       slow_i,
	input  wire       speed_i,
	output reg        tick_o
);
	reg  [1:0] cnt_q;      // Free count within one converter clock
	reg  [1:0] top;        // Last count value for the chosen ratio

	// Divider ratio from slow and speed
	always @* begin
		if (slow_i) begin
			top = 2'h3;
		end else if (speed_i) begin
			top = 2'h0;
		end else begin
			top = 2'h1;
		end
	end

	// Counter held cleared while stopped so each start begins a full period
	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q  <= 2'h0;
			tick_o <= 1'b0;
		end else if (cnt_q >= top) begin
			cnt_q  <= 2'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 2'h1;
			tick_o <= 1'b0;
		end
	end
endmodule

// ---- adcc_top.v ----
// Converter controller: Wishbone register file, conversion sequencer and analog-side controls.
// Assumes a classic Wishbone master on the CPU clock and a converter core that
// presents a sampled 10-bit code plus over and under reference flags.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
`include "adcc_map.vh"
module adcc_top #(
	parameter CONV_CLOCKS = `ADCC_CONV_CLOCKS,
	parameter STAB_CYCLES = `ADCC_STAB_CYCLES
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       wb_cyc_i,
	input  wire       wb_stb_i,
	input  wire       wb_we_i,
	input  wire [7:0] wb_adr_i,
	input  wire [3:0] wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg        wb_ack_o,
	input  wire [9:0] core_code_i,
	input  wire       core_over_i,
	input  wire       core_under_i,
	input  wire       halt_i,
	output reg  [2:0] mux_sel_o,
	output reg        core_power_o,
	output reg        amp_power_o,
	output reg        amp_route_o,
	output reg        amp_zero_o,
	output reg        sample_o,
	output reg        irq_o
);
	localparam ST_IDLE = 2'h0; // Converter off
	localparam ST_STAB = 2'h1; // Settling after halt wakeup
	localparam ST_CONV = 2'h2; // Converting

	reg  [1:0] state_q;        // Sequencer state
	reg  [2:0] channel_q;      // Channel field
	reg        on_q;           // Converter on
	reg        speed_q;        // Speed bit
	reg        done_q;         // Conversion done flag
	reg  [9:0] result_q;       // Whole result, loaded at once
	reg        cal_q;          // Amplifier calibration
	reg        slow_q;         // Slow mode
	reg        amp_q;          // Amplifier select
	reg  [3:0] bit_q;          // Converter clocks left in conversion, less one
	reg  [15:0] stab_q;        // Settling cycles left
	wire       tick;           // One converter clock
	wire       req;            // New bus access this cycle
	wire       wr;             // Write access
	wire [5:0] idx;            // Word index
	wire       end_conv;       // Conversion completes this cycle
	reg  [9:0] code;           // Saturated code

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = req && wb_we_i && wb_sel_i[0];
	assign idx = wb_adr_i[7:2];
	assign end_conv = (state_q == ST_CONV) && tick && (bit_q == 4'h0);

	// Converter clock runs only while converting; halt stops it outright
	adcc_clkdiv u_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.run_i   (state_q == ST_CONV),
		.slow_i  (slow_q),
		.speed_i (speed_q),
		.tick_o  (tick)
	);

	// Saturate the code at the references; no overflow flag exists
	always @* begin
		if (core_over_i) begin
			code = `ADCC_FULL_SCALE;
		end else if (core_under_i) begin
			code = `ADCC_ZERO_SCALE;
		end else begin
			code = core_code_i;
		end
	end

	// Sequencer: off, settle after halt, then convert back to back
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			bit_q   <= 4'h0;
			stab_q  <= 16'h0000;
		end else begin
			if (!on_q || halt_i) begin
				// Off or halted: no conversion runs
				state_q <= ST_IDLE;
				bit_q   <= CONV_CLOCKS[3:0] - 4'h1;
				if (halt_i) begin
					stab_q <= STAB_CYCLES[15:0];
				end
			end else begin
				case (state_q)
					ST_IDLE: begin
						// Wait out stabilisation left by a halt
						if (stab_q != 16'h0000) begin
							state_q <= ST_STAB;
						end else begin
							state_q <= ST_CONV;
						end
					end
					ST_STAB: begin
						if (stab_q <= 16'h0001) begin
							stab_q  <= 16'h0000;
							state_q <= ST_CONV;
						end else begin
							stab_q <= stab_q - 16'h0001;
						end
					end
					ST_CONV: begin
						if (tick) begin
							// Continuous: restart on the same channel at once
							if (bit_q == 4'h0) begin
								bit_q <= CONV_CLOCKS[3:0] - 4'h1;
							end else begin
								bit_q <= bit_q - 4'h1;
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Register writes, done flag and result capture
	always @(posedge clk_i) begin
		if (rst_i) begin
			channel_q <= 3'h0;
			on_q      <= 1'b0;
			speed_q   <= 1'b0;
			done_q    <= 1'b0;
			result_q  <= 10'h000;
			cal_q     <= 1'b0;
			slow_q    <= 1'b0;
			amp_q     <= 1'b0;
		end else begin
			if (wr && idx == `ADCC_IDX_CSR) begin
				// Done flag and reserved bits ignore writes
				speed_q   <= wb_dat_i[`ADCC_CSR_SPEED];
				on_q      <= wb_dat_i[`ADCC_CSR_ON];
				channel_q <= wb_dat_i[2:0];
			end else if (wr && idx == `ADCC_IDX_RES_LO) begin
				cal_q  <= wb_dat_i[`ADCC_LO_CAL];
				slow_q <= wb_dat_i[`ADCC_LO_SLOW];
				amp_q  <= wb_dat_i[`ADCC_LO_AMP];
			end
			if (end_conv) begin
				// Both halves load together; set beats a same-cycle read clear
				result_q <= code;
				done_q   <= 1'b1;
			end else if (req && !wb_we_i && idx == `ADCC_IDX_RES_HI) begin
				done_q <= 1'b0;
			end
		end
	end

	// Bus answer one cycle after the request; unmapped reads return zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h00000000;
			if (req && !wb_we_i) begin
				if (idx == `ADCC_IDX_CSR) begin
					wb_dat_o[7:0] <= {done_q, speed_q, on_q, 2'b00, channel_q};
				end else if (idx == `ADCC_IDX_RES_HI) begin
					wb_dat_o[7:0] <= result_q[9:2];
				end else if (idx == `ADCC_IDX_RES_LO) begin
					wb_dat_o[7:0] <= {3'b000, cal_q, slow_q, amp_q, result_q[1:0]};
				end
			end
		end
	end

	// Analog-side controls registered straight to the pins
	always @(posedge clk_i) begin
		if (rst_i) begin
			mux_sel_o    <= 3'h0;
			core_power_o <= 1'b0;
			amp_power_o  <= 1'b0;
			amp_route_o  <= 1'b0;
			amp_zero_o   <= 1'b0;
			sample_o     <= 1'b0;
			irq_o        <= 1'b0;
		end else begin
			mux_sel_o    <= channel_q;
			core_power_o <= on_q && !halt_i;
			amp_power_o  <= on_q && !halt_i;
			amp_route_o  <= amp_q;
			amp_zero_o   <= cal_q;
			sample_o     <= end_conv;
			irq_o        <= 1'b0;
		end
	end
endmodule

// ---- adcc_chk.sv ----
// Checker: bus and analog-control relations at the controller ports.
// Assumes it is bound onto adcc_top with matching port names.
`timescale 1ns/1ns
module adcc_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        halt_i,
	input wire        core_power_o,
	input wire        amp_power_o,
	input wire        sample_o,
	input wire        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	bus_width_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
	low_pad_a: assert property (wb_ack_o && wb_adr_i == 8'hd8 |-> wb_dat_o[7:5] == 3'h0)
		else $error("pad bits");
	no_irq_a: assert property (!irq_o) else $error("irq raised");
	amp_pwr_a: assert property (amp_power_o == core_power_o) else $error("amp power");
	halt_off_a: assert property (halt_i |=> !core_power_o) else $error("halt power");
	idle_conv_a: assert property ((!core_power_o)[*3] |-> !sample_o) else $error("idle sample");
	sample_once_a: assert property (sample_o |=> !sample_o) else $error("sample held");
endmodule

// ---- adcc_core_model.sv ----
// Converter core stand-in: code from channel, gain path and a level.
// Assumes the bench sets level and saturation; unpowered lines churn.
`timescale 1ns/1ns
module adcc_core_model (
	input  wire       clk_i,
	input  wire       pwr_i,
	input  wire [2:0] sel_i,
	input  wire       amp_i,
	input  wire       cal_i,
	input  wire [4:0] lvl_i,
	input  wire [1:0] sat_i,
	output wire [9:0] code_o,
	output wire       over_o,
	output wire       under_o
);
	reg  t = 1'b0;             // Toggles so stale codes never look valid
	wire z = t & ~pwr_i;       // Churn only while unpowered
	always @(posedge clk_i) t <= ~t;
	// Channel, gain and zeroed input shape the code
	assign code_o = {sel_i, amp_i, cal_i, lvl_i} ^ {10{z}};
	assign over_o = sat_i[0] ^ z;
	assign under_o = sat_i[1] ^ z;
endmodule

// ---- test_adcc_top.sv ----
// Bench: random converter settings over Wishbone, results compared.
// Assumes adcc_top, the core model and the checker compile first.
`timescale 1ns/1ns
module test_adcc_top;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         cyc = 1'b0;
	reg         we = 1'b0;
	reg  [7:0]  adr = 8'h0;
	reg  [7:0]  wd = 8'h0;
	reg         halt = 1'b0;
	reg  [4:0]  lvl = 5'h0;
	reg  [1:0]  sat = 2'h0;
	wire [31:0] rdat;
	wire        ack, pwr, apwr, route, zero, over, under;
	wire [2:0]  mux;
	wire [9:0]  code;
	integer     num_errors = 0, total_checks = 0, seed = 32'hd5f93842, i, n, k;
	reg  [7:0]  r, csr, lo;
	reg  [9:0]  e;
	initial forever #25 clk_i = ~clk_i;
	adcc_top #(.STAB_CYCLES(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wd}), .wb_dat_o(rdat),
		.wb_ack_o(ack), .core_code_i(code), .core_over_i(over), .core_under_i(under), .halt_i(halt),
		.mux_sel_o(mux), .core_power_o(pwr), .amp_power_o(apwr), .amp_route_o(route),
		.amp_zero_o(zero), .sample_o(), .irq_o());
	adcc_core_model core (.clk_i(clk_i), .pwr_i(pwr), .sel_i(mux), .amp_i(route), .cal_i(zero),
		.lvl_i(lvl), .sat_i(sat), .code_o(code), .over_o(over), .under_o(under));
	task close_out;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One classic cycle; request held until ack is sampled
	task wb(input w, input [7:0] a, input [7:0] d);
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n = n + 1;
		end
		r = rdat[7:0];
		cyc <= 1'b0;
		if (n == 50) begin
			num_errors = num_errors + 1;
			close_out;
		end
	endtask
	// Saturation overrides the raw code
	function [9:0] exp_code(input [1:0] s, input [9:0] raw);
		exp_code = (s == 2'd1) ? 10'h3ff : (s == 2'd2) ? 10'h000 : raw;
	endfunction
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'hd0, 8'h0);
		chk(r, 8'h00);
		wb(1'b0, 8'hdc, 8'h0);
		chk(r, 8'h00);
		for (i = 0; i < 12; i = i + 1) begin
			csr = $random(seed);
			csr[5] = 1'b1;
			csr[2:0] = csr[2:0] % 3'd7;
			csr[4:3] = 2'b00;
			lo = $random(seed); // Gain path tried at /4, the slowest divider this clock offers
			if (lo[2])
				lo[3] = 1'b1;
			lvl <= $random(seed);
			sat <= i % 3;
			wb(1'b1, 8'hd8, lo);
			wb(1'b1, 8'hd0, csr);
			@(negedge clk_i);
			chk({5'h0, mux}, {5'h0, csr[2:0]});
			chk({5'h0, route, zero, pwr & apwr}, {5'h0, lo[2], lo[4], 1'b1});
			wb(1'b0, 8'hd0, 8'h0);
			chk(r, {1'b0, csr[6:5], 2'b00, csr[2:0]});
			if (i == 5) begin
				halt <= 1'b1;
				repeat (4) @(posedge clk_i);
				halt <= 1'b0;
			end
			for (k = 0; k < 60 && r[7] !== 1'b1; k = k + 1)
				wb(1'b0, 8'hd0, 8'h0);
			chk({7'h0, r[7]}, 8'h01);
			e = exp_code(sat, {csr[2:0], lo[2], lo[4], lvl});
			wb(1'b0, 8'hd8, 8'h0);
			chk(r, {3'h0, lo[4:2], e[1:0]});
			wb(1'b0, 8'hd0, 8'h0);
			chk({7'h0, r[7]}, 8'h01);
			wb(1'b0, 8'hd4, 8'h0);
			chk(r, e[9:2]);
			wb(1'b0, 8'hd0, 8'h0);
			if (lo[3])
				chk({7'h0, r[7]}, 8'h00);
			wb(1'b1, 8'hd0, 8'h0);
			wb(1'b0, 8'hd4, 8'h0);
			@(negedge clk_i);
			chk({6'h0, pwr, apwr}, 8'h00);
		end
		close_out;
	end
endmodule
bind adcc_top adcc_chk chk_u (.*);
